// [rtl/amg_ctrl.sv]
// Top: APB register file and analog front-end control for the sar converter
//
// Operation
// - Converter, hold, gain run only when enabled
// - Nine selectable channels into 12-bit converter
// - Each pair software-switchable differential or single
// - Reset makes all pairs single-ended
// - Three-bit gain code scales selected signal
// - Gain is unity after reset
// - Any port-3 pin combination may be selected
// - Even pins one input, odd another
// - HV amplifier selectable like other channels
// - Four-bit channel code selects source
// - Four pairing bits, reset to zero
// - Differential pair yields two's complement result
// - Eight pin-enable bits, cleared by reset
`timescale 1ns/1ps
module amg_ctrl (
    // Clock and reset
    input  wire logic                pclk,
    input  wire logic                presetn,
    // APB slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    input  wire logic [3:0]          pstrb,
    output logic                     pready,
    output logic [31:0]              prdata,
    output logic                     pslverr,
    // Power control of the analog subsystem
    output logic                     converter_power,
    output logic                     hold_power,
    output logic                     gain_stage_power,
    // Selector and gain stage controls
    output amg_pkg::amg_src_type     pos_src,
    output amg_pkg::amg_src_type     neg_src,
    output logic                     neg_used,
    output logic                     twos_complement,
    output logic [2:0]               gain_select_field,
    output logic [7:0]               port_pin_analog_enable,
    output logic                     even_port_group_active,
    output logic                     odd_port_group_active
);
    import amg_pkg::*;

    logic                subsystem_enable;
    logic [2:0]          gain_code;
    logic [3:0]          channel_code_field;
    logic [3:0]          pair_cfg;
    logic [7:0]          port_pins;
    logic                wr_en;
    logic                rd_en;
    logic                addr_ok;
    logic [31:0]         next_rdata;
    amg_src_type         rt_pos;
    amg_src_type         rt_neg;
    logic                rt_neg_used;
    logic                rt_twos;

    // Single-cycle access phase; zero wait states
    assign pready  = 1'b1;
    assign wr_en   = psel && penable && pwrite && pstrb[0];
    assign rd_en   = psel && penable && !pwrite;

    // Address decode; unmapped words answer with an error
    always_comb begin
        case (paddr)
            ADDR_CONTROL, ADDR_CONFIG, ADDR_CHANNEL,
            ADDR_PAIR, ADDR_PORT_PINS, ADDR_ROUTE: begin
                addr_ok = 1'b1;
            end
            default: begin
                addr_ok = 1'b0;
            end
        endcase
    end
    assign pslverr = psel && penable && !addr_ok;

    // Control register: enable bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            subsystem_enable <= 1'b0;
        end else if (wr_en && paddr == ADDR_CONTROL) begin
            subsystem_enable <= pwdata[ENABLE_BIT];
        end
    end

    // Configuration register: gain code
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gain_code <= GAIN_RESET;
        end else if (wr_en && paddr == ADDR_CONFIG) begin
            gain_code <= pwdata[GAIN_LSB +: GAIN_WIDTH];
        end
    end

    // Channel select register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            channel_code_field <= CHAN_RESET;
        end else if (wr_en && paddr == ADDR_CHANNEL) begin
            channel_code_field <= pwdata[CHAN_WIDTH-1:0];
        end
    end

    // Pair configuration register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pair_cfg <= PAIR_RESET;
        end else if (wr_en && paddr == ADDR_PAIR) begin
            pair_cfg <= pwdata[PAIR_WIDTH-1:0];
        end
    end

    // Port pin selection register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_pins <= PORT_RESET;
        end else if (wr_en && paddr == ADDR_PORT_PINS) begin
            port_pins <= pwdata[PORT_WIDTH-1:0];
        end
    end

    // Route decode of channel and pairing
    amg_route u_route (
        .channel_code_field (channel_code_field),
        .pair_cfg           (pair_cfg),
        .pos_src            (rt_pos),
        .neg_used           (rt_neg_used),
        .neg_src            (rt_neg),
        .twos_complement    (rt_twos)
    );

    // outputs follow the registers straight away
    always_comb begin
        pos_src         = rt_pos;
        neg_src         = rt_neg;
        neg_used        = rt_neg_used;
        twos_complement = rt_twos;
        gain_select_field = gain_code;
    end

    // shutdown of converter, hold and gain stage
    assign converter_power  = subsystem_enable;
    assign hold_power       = subsystem_enable;
    assign gain_stage_power = subsystem_enable;

    // even pins tie together, odd pins tie together
    assign port_pin_analog_enable = port_pins;
    assign even_port_group_active = |(port_pins & 8'h55);
    assign odd_port_group_active  = |(port_pins & 8'haa);

    // Read mux; reserved bits read zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        case (paddr)
            ADDR_CONTROL:   next_rdata[0]   = subsystem_enable;
            ADDR_CONFIG:    next_rdata[2:0] = gain_code;
            ADDR_CHANNEL:   next_rdata[3:0] = channel_code_field;
            ADDR_PAIR:      next_rdata[3:0] = pair_cfg;
            ADDR_PORT_PINS: next_rdata[7:0] = port_pins;
            // Live routing state, read only
            ADDR_ROUTE: begin
                next_rdata[3:0] = rt_pos;
                next_rdata[7:4] = rt_neg;
                next_rdata[8]   = rt_neg_used;
                next_rdata[9]   = rt_twos;
            end
            default:        next_rdata = 32'h0000_0000;
        endcase
    end

    // Read data held in a register, loaded in setup phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= next_rdata;
        end
    end
endmodule : amg_ctrl

// [rtl/amg_pkg.sv]
// Package: register map, field layout and reset values of the input selector control
package amg_pkg;
    // Register byte addresses on the APB slave
    localparam logic [7:0] ADDR_CONTROL    = 8'h00;
    localparam logic [7:0] ADDR_CONFIG     = 8'h04;
    localparam logic [7:0] ADDR_CHANNEL    = 8'h08;
    localparam logic [7:0] ADDR_PAIR       = 8'h0c;
    localparam logic [7:0] ADDR_PORT_PINS  = 8'h10;
    localparam logic [7:0] ADDR_ROUTE      = 8'h14;
    // Field positions
    localparam int ENABLE_BIT      = 0;
    localparam int GAIN_LSB        = 0;
    localparam int GAIN_WIDTH      = 3;
    localparam int CHAN_WIDTH      = 4;
    localparam int PAIR_WIDTH      = 4;
    localparam int PORT_WIDTH      = 8;
    localparam int PAIR_AIN01      = 0;
    localparam int PAIR_AIN23      = 1;
    localparam int PAIR_HV         = 2;
    localparam int PAIR_PORT       = 3;
    // Reset values
    localparam logic [2:0] GAIN_RESET = 3'h0;   // Unity gain code
    localparam logic [3:0] CHAN_RESET = 4'h0;
    localparam logic [3:0] PAIR_RESET = 4'h0;
    localparam logic [7:0] PORT_RESET = 8'h00;
    // Gain codes
    localparam logic [2:0] GAIN_X1   = 3'h0;
    localparam logic [2:0] GAIN_X2   = 3'h1;
    localparam logic [2:0] GAIN_X4   = 3'h2;
    localparam logic [2:0] GAIN_X8   = 3'h3;
    localparam logic [2:0] GAIN_X16  = 3'h4;
    localparam logic [2:0] GAIN_XHALF = 3'h6;
    // Routed selector sources
    typedef enum logic [3:0] {
        SRC_AIN0     = 4'b0000,
        SRC_AIN1     = 4'b0001,
        SRC_AIN2     = 4'b0010,
        SRC_AIN3     = 4'b0011,
        SRC_HV       = 4'b0100,
        SRC_AGND     = 4'b0101,
        SRC_PORT_EVN = 4'b0110,
        SRC_PORT_ODD = 4'b0111,
        SRC_TEMP     = 4'b1000
    } amg_src_type;
endpackage : amg_pkg

// [rtl/amg_route.sv]
// Routing decode: channel code and pairing bits to selector switch controls
`timescale 1ns/1ps
module amg_route (
    // Configuration in
    input  wire logic [3:0]         channel_code_field,
    input  wire logic [3:0]         pair_cfg,
    // Switch controls out
    output amg_pkg::amg_src_type    pos_src,
    output logic                    neg_used,
    output amg_pkg::amg_src_type    neg_src,
    output logic                    twos_complement
);
    import amg_pkg::*;

    // Decode the positive and negative legs of the selected channel
    always_comb begin
        pos_src         = SRC_AIN0;
        neg_src         = SRC_AGND;
        neg_used        = 1'b0;
        if (channel_code_field[3]) begin
            pos_src = SRC_TEMP;
        end else begin
            case (channel_code_field[2:0])
                3'h0, 3'h1: begin
                    if (pair_cfg[PAIR_AIN01]) begin
                        pos_src  = SRC_AIN0;
                        neg_src  = SRC_AIN1;
                        neg_used = 1'b1;
                    end else begin
                        pos_src = channel_code_field[0] ? SRC_AIN1 : SRC_AIN0;
                    end
                end
                3'h2, 3'h3: begin
                    if (pair_cfg[PAIR_AIN23]) begin
                        pos_src  = SRC_AIN2;
                        neg_src  = SRC_AIN3;
                        neg_used = 1'b1;
                    end else begin
                        pos_src = channel_code_field[0] ? SRC_AIN3 : SRC_AIN2;
                    end
                end
                3'h4, 3'h5: begin
                    // high-voltage amp routed like any channel
                    if (pair_cfg[PAIR_HV]) begin
                        pos_src  = SRC_HV;
                        neg_used = 1'b1;   // Negative leg stays on analog ground
                    end else begin
                        pos_src = channel_code_field[0] ? SRC_AGND : SRC_HV;
                    end
                end
                3'h6, 3'h7: begin
                    if (pair_cfg[PAIR_PORT]) begin
                        pos_src  = SRC_PORT_EVN;
                        neg_src  = SRC_PORT_ODD;
                        neg_used = 1'b1;
                    end else begin
                        pos_src = channel_code_field[0] ? SRC_PORT_ODD : SRC_PORT_EVN;
                    end
                end
                default: begin
                    pos_src = SRC_AIN0;
                end
            endcase
        end
    end

    assign twos_complement = neg_used;
endmodule : amg_route

// [test/amg_ctrl_checker.sv]
// Checker: concurrent properties on the top ports of the selector control
`timescale 1ns/1ps
module amg_ctrl_checker (
    // Clock, reset and APB
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic        pready,
    input wire logic        pslverr,
    // Front-end controls
    input wire logic        converter_power,
    input wire logic        hold_power,
    input wire logic [2:0]  gain_select_field,
    input wire logic [7:0]  port_pin_analog_enable,
    input wire logic        even_port_group_active,
    input wire logic        odd_port_group_active,
    input wire logic        neg_used,
    input wire logic        twos_complement
);
    import amg_pkg::*;
    logic wr;
    // Completed write with the low byte strobed
    assign wr = psel && penable && pwrite && pstrb[0];
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_power_write: assert property (wr && paddr == ADDR_CONTROL |=>
        converter_power == $past(pwdata[0]) && hold_power == converter_power)
        else $error("power does not follow enable write");
    chk_gain_write: assert property (wr && paddr == ADDR_CONFIG |=>
        gain_select_field == $past(pwdata[2:0])) else $error("gain code not stored");
    chk_pin_write: assert property (wr && paddr == ADDR_PORT_PINS |=>
        port_pin_analog_enable == $past(pwdata[7:0])) else $error("pin enables not stored");
    chk_pin_hold: assert property (!(wr && paddr == ADDR_PORT_PINS) |=>
        $stable(port_pin_analog_enable)) else $error("pin enables changed without write");
    chk_even_group: assert property (even_port_group_active ==
        |(port_pin_analog_enable & 8'h55)) else $error("even group wrong");
    chk_odd_group: assert property (odd_port_group_active ==
        |(port_pin_analog_enable & 8'haa)) else $error("odd group wrong");
    chk_twos_diff: assert property (twos_complement == neg_used)
        else $error("result format does not follow differential mode");
    chk_single_ended: assert property (wr && paddr == ADDR_PAIR && pwdata[3:0] == 4'h0 |=>
        !neg_used && !twos_complement) else $error("pairs not single-ended after clear");
    chk_bad_addr: assert property (psel && penable && paddr > ADDR_ROUTE |->
        pslverr && pready) else $error("unmapped access not refused");
    cover property (wr && paddr == ADDR_CONTROL && pwdata[0]);
    cover property ($rose(neg_used));
    cover property (psel && penable && pslverr);
endmodule : amg_ctrl_checker
bind amg_ctrl amg_ctrl_checker u_chk (.*);

// [test/testbench.sv]
// Testbench: APB register and selector routing checks
`timescale 1ns/1ps
module testbench;
    import amg_pkg::*;
    // Design signals
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr, port_pin_analog_enable;
    logic [31:0] pwdata, prdata;
    logic [3:0]  pstrb;
    logic        converter_power, hold_power, gain_stage_power, neg_used, twos_complement;
    logic        even_port_group_active, odd_port_group_active;
    logic [2:0]  gain_select_field;
    amg_src_type pos_src, neg_src;
    logic [8:0]  r;
    logic [7:0]  pin;
    logic [31:0] q_seen;
    logic        e_seen;
    int          n_fail, checked, i, j;
    amg_ctrl dut (.*);
    // Free-running 10 MHz clock
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    task automatic tally_and_finish();
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // One APB transfer; waits for pready under a bound
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                       input logic [3:0] s, output logic [31:0] q, output logic e);
        int k;
        k = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        if (pready !== 1'b1) begin
            n_fail++;
            tally_and_finish();
        end
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Write, then let the register update land before looking
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] q;
        logic        e;
        apb(a, 1'b1, d, s, q, e);
        @(negedge pclk);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic        e;
        apb(a, 1'b0, 32'h0, 4'h0, q, e);
        check(q, exp);
    endtask : rd
    // Expected {neg_used, neg_src, pos_src} for a code and pairing bits
    function automatic logic [8:0] exp_route(input logic [3:0] c, input logic [3:0] p);
        exp_route = {1'b0, 4'h5, c};
        if (c[3]) exp_route[3:0] = 4'h8;
        else if (c[2:1] == 2'b00 && p[0]) exp_route = 9'h110;
        else if (c[2:1] == 2'b01 && p[1]) exp_route = 9'h132;
        else if (c[2:1] == 2'b10 && p[2]) exp_route = 9'h154;
        else if (c[2:1] == 2'b11 && p[3]) exp_route = 9'h176;
    endfunction : exp_route
    initial begin
        {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        presetn = 1'b0;
        n_fail  = 0;
        checked = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        // reset values, all single-ended, unity gain, pins cleared
        rd(ADDR_CONTROL, 32'h0);
        rd(ADDR_CONFIG, {29'h0, GAIN_X1});
        rd(ADDR_PAIR, 32'h0);
        rd(ADDR_PORT_PINS, 32'h0);
        rd(ADDR_ROUTE, 32'h50);
        check({converter_power, gain_stage_power, gain_select_field}, {2'b0, GAIN_X1});
        // power follows the enable bit, a dead strobe is ignored
        wr(ADDR_CONTROL, 32'h1, 4'hf);
        check({hold_power, converter_power, gain_stage_power}, 3'h7);
        wr(ADDR_CONTROL, 32'h0, 4'hf);
        check({hold_power, converter_power, gain_stage_power}, 3'h0);
        wr(ADDR_CONTROL, 32'h1, 4'h0);
        check(converter_power, 1'b0);
        for (i = 0; i < 8; i++) begin
            wr(ADDR_CONFIG, i, 4'hf);
            check(gain_select_field, i[2:0]);
            rd(ADDR_CONFIG, i);
        end
        for (i = 0; i < 10; i++) begin
            pin = (i < 8) ? 8'h01 << i : ((i == 8) ? 8'h00 : 8'hff);
            wr(ADDR_PORT_PINS, pin, 4'hf);
            check({even_port_group_active, odd_port_group_active}, {|(pin & 8'h55), |(pin & 8'haa)});
            rd(ADDR_PORT_PINS, pin);
        end
        // Unmapped place: refused with an error and reads zero; a mapped read is not refused
        apb(8'h18, 1'b1, 32'hff, 4'hf, q_seen, e_seen);
        check(e_seen, 1'b1);
        apb(8'h18, 1'b0, 32'h0, 4'h0, q_seen, e_seen);
        check(q_seen, 32'h0);
        check(e_seen, 1'b1);
        apb(ADDR_PAIR, 1'b0, 32'h0, 4'h0, q_seen, e_seen);
        check(e_seen, 1'b0);
        wr(ADDR_PAIR, 32'hffff_ffff, 4'hf);
        rd(ADDR_PAIR, 32'hf);
        // every code under every pairing, changed on the fly
        for (i = 0; i < 16; i++) begin
            wr(ADDR_PAIR, i, 4'hf);
            for (j = 0; j < 16; j++) begin
                wr(ADDR_CHANNEL, j, 4'hf);
                r = exp_route(j[3:0], i[3:0]);
                check({neg_used, neg_src, pos_src}, r);
                check(twos_complement, r[8]);
                rd(ADDR_ROUTE, {r[8], r});
                rd(ADDR_CHANNEL, j);
            end
        end
        // Second reset in mid-run, with every setting away from its reset value
        wr(ADDR_CONTROL, 32'h1, 4'hf);
        check(converter_power, 1'b1);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd(ADDR_PAIR, 32'h0);
        rd(ADDR_CONFIG, {29'h0, GAIN_X1});
        rd(ADDR_PORT_PINS, 32'h0);
        rd(ADDR_ROUTE, 32'h50);
        check({converter_power, hold_power, gain_stage_power}, 3'h0);
        tally_and_finish();
    end
endmodule : testbench
